// [rtl/fqm_core.v]
// Serial flash command interpreter: IDs, read set-up, four-wire mode.
// Assumes pins from another clock domain and an Avalon-MM master on clk.
// What this block does
// - Quad ID: opcode, 24 zero address bits quad
// - Then mode byte, four dummies, then output
// - ID nibbles out on falling edge MSB first
// - Maker/device alternate until select rises
// - Unique read: opcode, 32 dummy clocks, out
// - 128-bit unique number fixed, unalterable
// - Read-parameter opcode ignored outside four-wire mode
// - Dummy field: 4, 6, 8, 8 clocks
// - Wrap field: 8, 16, 32, 64 bytes
// - Reset gives 8-byte wrap, 4 dummies
// - Programmed dummies only for four-wire reads
// - Serial wrap from opcode; kept over switches
// - Wrapped read returns to aligned window start
// - Only enter opcode selects four-wire mode
// - Enter ignored while quad enable clear
// - Start serial; never both modes together
// - Entering keeps latch, suspend, wrap
// - Exit opcode returns; latch, suspend, wrap kept
//
// Register access over Avalon-MM and the address map were decided locally.
`timescale 1ns/1ps
`include "fqm_defs.vh"
module fqm_core #(
	parameter [7:0] MAKER_CODE = 8'h5a, // Arbitrary value
	parameter [7:0] DEVICE_CODE = 8'h3c, // Arbitrary value
	parameter [127:0] UNIQUE_NUMBER = 128'h0123456789abcdeffedcba9876543210
) (
	input wire clk,
	input wire rst_n,
	input wire sck_pin,
	input wire cs_n_pin,
	input wire [3:0] io_in,
	output reg [3:0] io_out,
	output reg [3:0] io_oe,
	input wire [3:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest
);
	// Phase states
	localparam [2:0] ST_OPC = 3'h0;
	localparam [2:0] ST_ADDR = 3'h1;
	localparam [2:0] ST_MODE = 3'h2;
	localparam [2:0] ST_DUMMY = 3'h3;
	localparam [2:0] ST_DOUT = 3'h4;
	localparam [2:0] ST_PARAM = 3'h5;
	localparam [2:0] ST_SKIP = 3'h6;
	// Output kinds
	localparam [1:0] K_ID = 2'h0;
	localparam [1:0] K_UID = 2'h1;
	localparam [1:0] K_RD = 2'h2;

	reg sck_s1, sck_s2, sck_d; // Serial clock synchroniser and history
	reg cs_s1, cs_s2; // Select synchroniser
	reg [3:0] io_s1, io_s2; // Data synchroniser
	reg [2:0] state; // Phase of the current frame
	reg [5:0] cnt; // Clocks seen in the phase
	reg [5:0] need; // Clocks the phase lasts
	reg quad_in; // Four bits per clock in
	reg quad_out; // Four bits per clock out
	reg [1:0] kind; // What the output phase sends
	reg wrap_on; // Burst wraps inside its window
	reg mode_next; // Mode byte follows the address
	reg [5:0] dummy_after; // Dummy clocks after address
	reg set_wrap; // Parameter phase is the serial wrap form
	reg [23:0] sr; // Input shifter
	reg [23:0] addr; // Read address
	reg [6:0] ocnt; // Output beat counter
	reg four_wire_command_mode; // Mode flag, single bit for both modes
	reg [1:0] dummy_count_field; // Programmed dummy selection
	reg [1:0] wrap_size_field; // Wrap length selection
	reg rst_armed; // Reset enable seen
	reg [7:0] last_op; // Last decoded opcode
	reg quad_enable_bit; // Software-set quad enable
	reg write_latch_flag; // Software-held write latch
	reg suspend_flag; // Software-held suspend status
	reg [7:0] pattern; // Read data scrambler

	wire rise = sck_s2 & ~sck_d & ~cs_s2; // Rising serial edge in frame
	wire fall = ~sck_s2 & sck_d & ~cs_s2; // Falling serial edge in frame
	wire last = (cnt == need - 6'h01); // Final clock of the phase
	wire [23:0] next_sr = quad_in ? {sr[19:0], io_s2} : {sr[22:0], io_s2[0]};
	wire [7:0] op = next_sr[7:0]; // Opcode at the end of its phase
	wire [15:0] id_word = {MAKER_CODE, DEVICE_CODE};
	wire [15:0] id_sh = id_word >> {~ocnt[1:0], 2'b00};
	wire [7:0] rd_byte = addr[7:0] ^ pattern; // Stand-in array content
	wire byte_end = quad_out ? ocnt[0] : (ocnt[2:0] == 3'h7);
	reg [5:0] dummy_prog; // Dummies from the programmed field
	reg [23:0] wrap_mask; // Window mask for wrapped bursts
	reg [23:0] next_addr; // Address after the current byte
	reg [3:0] next_bits; // Bits driven at the next falling edge

	// Dummy count decode
	always @* begin
		case (dummy_count_field)
			2'h0: dummy_prog = `FQM_DUMMY_SEL0;
			2'h1: dummy_prog = `FQM_DUMMY_SEL1;
			default: dummy_prog = `FQM_DUMMY_SEL2;
		endcase
	end

	// Wrap window and address advance
	always @* begin
		case (wrap_size_field)
			2'h0: wrap_mask = 24'h000007;
			2'h1: wrap_mask = 24'h00000f;
			2'h2: wrap_mask = 24'h00001f;
			default: wrap_mask = 24'h00003f;
		endcase
		if (wrap_on) begin
			next_addr = (addr & ~wrap_mask) | ((addr + 24'h1) & wrap_mask);
		end else begin
			next_addr = addr + 24'h1;
		end
	end

	// Output bit selection
	always @* begin
		next_bits = 4'h0;
		case (kind)
			K_ID: next_bits = id_sh[3:0];
			K_UID: next_bits = {2'b00, UNIQUE_NUMBER[~ocnt], 1'b0};
			default: begin
				if (quad_out) begin
					next_bits = ocnt[0] ? rd_byte[3:0] : rd_byte[7:4];
				end else begin
					next_bits = {2'b00, rd_byte[~ocnt[2:0]], 1'b0};
				end
			end
		endcase
	end

	// Pin synchronisers
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sck_s1 <= 1'b0;
			sck_s2 <= 1'b0;
			sck_d <= 1'b0;
			cs_s1 <= 1'b1;
			cs_s2 <= 1'b1;
			io_s1 <= 4'h0;
			io_s2 <= 4'h0;
		end else begin
			sck_s1 <= sck_pin;
			sck_s2 <= sck_s1;
			sck_d <= sck_s2;
			cs_s1 <= cs_n_pin;
			cs_s2 <= cs_s1;
			io_s1 <= io_in;
			io_s2 <= io_s1;
		end
	end

	// Frame sequencer
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_OPC;
			cnt <= 6'h00;
			need <= `FQM_OPC_SERIAL;
			quad_in <= 1'b0;
			quad_out <= 1'b0;
			kind <= K_ID;
			wrap_on <= 1'b0;
			mode_next <= 1'b0;
			dummy_after <= `FQM_DUMMY_ID;
			set_wrap <= 1'b0;
			sr <= 24'h0;
			addr <= 24'h0;
			ocnt <= 7'h00;
			four_wire_command_mode <= 1'b0;
			dummy_count_field <= `FQM_DUMMY_FIELD_RST;
			wrap_size_field <= `FQM_WRAP_FIELD_RST;
			rst_armed <= 1'b0;
			last_op <= 8'h00;
			io_out <= 4'h0;
			io_oe <= 4'h0;
		end else if (cs_s2) begin
			// Select high: idle, pins released
			state <= ST_OPC;
			cnt <= 6'h00;
			quad_in <= four_wire_command_mode;
			need <= four_wire_command_mode ? `FQM_OPC_QUAD : `FQM_OPC_SERIAL;
			io_oe <= 4'h0;
		end else if (fall && state == ST_DOUT) begin
			// Drive the next beat
			io_out <= next_bits;
			io_oe <= quad_out ? 4'hf : 4'h2;
			ocnt <= ocnt + 7'h01;
			if (kind == K_RD && byte_end) begin
				addr <= next_addr;
			end
		end else if (rise) begin
			sr <= next_sr;
			cnt <= last ? 6'h00 : cnt + 6'h01;
			case (state)
				ST_OPC: begin
					if (last) begin
						last_op <= op;
						rst_armed <= (op == `FQM_OP_RST_EN);
						state <= ST_SKIP;
						wrap_on <= 1'b0;
						mode_next <= 1'b0;
						kind <= K_RD;
						case (op)
							`FQM_OP_QUAD_ID: begin
								state <= ST_ADDR;
								quad_in <= 1'b1;
								need <= `FQM_ADDR_QUAD;
								mode_next <= 1'b1;
								dummy_after <= `FQM_DUMMY_ID;
								kind <= K_ID;
								quad_out <= 1'b1;
							end
							`FQM_OP_UNIQUE: begin
								if (!four_wire_command_mode) begin
									state <= ST_DUMMY;
									need <= `FQM_DUMMY_UNIQUE;
									kind <= K_UID;
									quad_out <= 1'b0;
								end
							end
							`FQM_OP_FAST: begin
								state <= ST_ADDR;
								quad_in <= four_wire_command_mode;
								quad_out <= four_wire_command_mode;
								if (four_wire_command_mode) begin
									need <= `FQM_ADDR_QUAD;
									dummy_after <= dummy_prog;
								end else begin
									need <= `FQM_ADDR_SERIAL;
									dummy_after <= `FQM_DUMMY_FAST_SER;
								end
							end
							`FQM_OP_QUAD_FAST: begin
								state <= ST_ADDR;
								quad_in <= 1'b1;
								quad_out <= 1'b1;
								need <= `FQM_ADDR_QUAD;
								mode_next <= ~four_wire_command_mode;
								dummy_after <= four_wire_command_mode ?
									dummy_prog : `FQM_DUMMY_QFAST_SER;
							end
							`FQM_OP_WRAP_READ: begin
								if (four_wire_command_mode) begin
									state <= ST_ADDR;
									quad_out <= 1'b1;
									need <= `FQM_ADDR_QUAD;
									dummy_after <= dummy_prog;
									wrap_on <= 1'b1;
								end
							end
							`FQM_OP_SET_PARAM: begin
								if (four_wire_command_mode) begin
									state <= ST_PARAM;
									need <= `FQM_PARAM_QPI_CLKS;
									set_wrap <= 1'b0;
								end
							end
							`FQM_OP_SET_WRAP: begin
								if (!four_wire_command_mode) begin
									state <= ST_PARAM;
									quad_in <= 1'b1;
									need <= `FQM_PARAM_WRAP_CLKS;
									set_wrap <= 1'b1;
								end
							end
							`FQM_OP_ENTER: begin
								// Latch, suspend and wrap are untouched
								if (quad_enable_bit) begin
									four_wire_command_mode <= 1'b1;
								end
							end
							`FQM_OP_EXIT: begin
								four_wire_command_mode <= 1'b0;
							end
							`FQM_OP_RST: begin
								if (rst_armed) begin
									dummy_count_field <= `FQM_DUMMY_FIELD_RST;
									wrap_size_field <= `FQM_WRAP_FIELD_RST;
									four_wire_command_mode <= 1'b0;
								end
							end
							default: state <= ST_SKIP;
						endcase
					end
				end
				ST_ADDR: begin
					if (last) begin
						addr <= next_sr;
						state <= mode_next ? ST_MODE : ST_DUMMY;
						need <= mode_next ? `FQM_MODE_CLKS : dummy_after;
					end
				end
				ST_MODE: begin
					// Mode byte is taken and not acted on
					if (last) begin
						state <= ST_DUMMY;
						need <= dummy_after;
					end
				end
				ST_DUMMY: begin
					if (last) begin
						state <= ST_DOUT;
						ocnt <= 7'h00;
					end
				end
				ST_PARAM: begin
					if (last) begin
						state <= ST_SKIP;
						if (set_wrap) begin
							wrap_size_field <=
								next_sr[`FQM_SER_WRAP_HI:`FQM_SER_WRAP_LO];
						end else begin
							dummy_count_field <=
								next_sr[`FQM_PARAM_DUMMY_HI:`FQM_PARAM_DUMMY_LO];
							wrap_size_field <=
								next_sr[`FQM_PARAM_WRAP_HI:`FQM_PARAM_WRAP_LO];
						end
					end
				end
				ST_DOUT, ST_SKIP: state <= state;
				default: state <= ST_SKIP;
			endcase
		end
	end

	// Avalon-MM slave: one wait cycle, then the answer
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0;
			quad_enable_bit <= 1'b0;
			write_latch_flag <= 1'b0;
			suspend_flag <= 1'b0;
			pattern <= `FQM_PATTERN_RST;
		end else begin
			avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
			if (avs_read && avs_waitrequest) begin
				case (avs_address)
					`FQM_REG_CTRL: avs_readdata <= {29'h0, suspend_flag,
						write_latch_flag, quad_enable_bit};
					`FQM_REG_STATUS: avs_readdata <= {15'h0, ~cs_s2, 6'h0,
						wrap_size_field, 2'h0, dummy_count_field, 3'h0,
						four_wire_command_mode};
					`FQM_REG_PATTERN: avs_readdata <= {24'h0, pattern};
					`FQM_REG_LASTOP: avs_readdata <= {24'h0, last_op};
					default: avs_readdata <= 32'h0;
				endcase
			end
			if (avs_write && !avs_waitrequest && avs_byteenable[0]) begin
				case (avs_address)
					`FQM_REG_CTRL: begin
						quad_enable_bit <= avs_writedata[0];
						write_latch_flag <= avs_writedata[1];
						suspend_flag <= avs_writedata[2];
					end
					`FQM_REG_PATTERN: pattern <= avs_writedata[7:0];
					default: pattern <= pattern;
				endcase
			end
		end
	end
endmodule // fqm_core

// [rtl/fqm_defs.vh]
// Constants for the quad identification and read set-up interpreter.
// Assumes inclusion by the one design file that uses them.
`ifndef FQM_DEFS_VH
`define FQM_DEFS_VH
// Opcodes
`define FQM_OP_QUAD_ID 8'h94
`define FQM_OP_UNIQUE 8'h4b
`define FQM_OP_SET_PARAM 8'hc0
`define FQM_OP_WRAP_READ 8'h0c
`define FQM_OP_FAST 8'h0b
`define FQM_OP_QUAD_FAST 8'heb
`define FQM_OP_SET_WRAP 8'h77
`define FQM_OP_ENTER 8'h38
`define FQM_OP_EXIT 8'hff
`define FQM_OP_RST_EN 8'h66
`define FQM_OP_RST 8'h99
// Phase lengths in serial clocks
`define FQM_OPC_SERIAL 6'h08
`define FQM_OPC_QUAD 6'h02
`define FQM_ADDR_SERIAL 6'h18
`define FQM_ADDR_QUAD 6'h06
`define FQM_MODE_CLKS 6'h02
`define FQM_DUMMY_ID 6'h04
`define FQM_DUMMY_UNIQUE 6'h20
`define FQM_DUMMY_FAST_SER 6'h08
`define FQM_DUMMY_QFAST_SER 6'h04
`define FQM_DUMMY_SEL0 6'h04
`define FQM_DUMMY_SEL1 6'h06
`define FQM_DUMMY_SEL2 6'h08
`define FQM_PARAM_QPI_CLKS 6'h02
`define FQM_PARAM_WRAP_CLKS 6'h08
// Field positions
`define FQM_PARAM_DUMMY_HI 5
`define FQM_PARAM_DUMMY_LO 4
`define FQM_PARAM_WRAP_HI 1
`define FQM_PARAM_WRAP_LO 0
`define FQM_SER_WRAP_HI 6
`define FQM_SER_WRAP_LO 5
// Reset values
`define FQM_DUMMY_FIELD_RST 2'h0
`define FQM_WRAP_FIELD_RST 2'h0
`define FQM_PATTERN_RST 8'h00
// Register byte offsets
`define FQM_REG_CTRL 4'h0
`define FQM_REG_STATUS 4'h4
`define FQM_REG_PATTERN 4'h8
`define FQM_REG_LASTOP 4'hc
`endif

// [testbench/fqm_core_assertions.sv]
// Checker for the flash command interpreter ports.
// Assumes a bind onto fqm_core from the bench top.
`timescale 1ns/1ps
module fqm_core_assertions (
	input wire clk,
	input wire rst_n,
	input wire sck_pin,
	input wire cs_n_pin,
	input wire [3:0] io_out,
	input wire [3:0] io_oe,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_readdata,
	input wire avs_waitrequest
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Bus access steps
	sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
	sequence s_ack; !avs_waitrequest; endsequence
	a_bus_answer: assert property (s_req |=> s_ack)
		else $error("bus access not answered");
	a_ack_single: assert property (s_ack |=> avs_waitrequest)
		else $error("answer longer than one cycle");
	a_ack_cause: assert property (s_ack |-> $past(avs_read || avs_write))
		else $error("answer without request");
	a_rdata_hold: assert property ($changed(avs_readdata) |-> s_ack)
		else $error("read data moved outside an answer");
	a_oe_legal: assert property (io_oe inside {4'h0, 4'h2, 4'hf})
		else $error("bad enable pattern");
	a_out_fall: assert property ($changed(io_out) && |io_oe &&
		|$past(io_oe) |-> !sck_pin) else $error("output moved on rise");
	a_oe_frame: assert property (|io_oe |-> !$past(cs_n_pin, 4))
		else $error("driving outside a frame");
	a_oe_start: assert property ($rose(|io_oe) |-> !sck_pin && !cs_n_pin)
		else $error("output began off a falling edge");
endmodule // fqm_core_assertions

// [testbench/fqm_host.sv]
// Host controller model: drives select, serial clock and data lines.
// Assumes clk at 5 ns; serial clock period is 16 clk (80 ns).
`timescale 1ns/1ps
module fqm_host (
	input wire clk,
	input wire [3:0] io_out,
	input wire [3:0] io_oe,
	output logic sck_pin,
	output logic cs_n_pin,
	output wire [3:0] io_in
);
	logic [3:0] h_d; // Host data
	logic [3:0] h_oe; // Host enables
	logic flip = 0; // Released lines toggle
	initial begin
		sck_pin = 0;
		cs_n_pin = 1;
		h_d = 0;
		h_oe = 0;
	end
	always @(posedge clk) flip <= ~flip;
	// Wire level from both parties
	assign io_in = (io_oe & io_out) | (~io_oe & h_oe & h_d) |
		(~io_oe & ~h_oe & {4{flip}});
	task automatic half();
		repeat (8) @(posedge clk);
	endtask
	// One serial clock, data sampled at the rise
	task automatic beat(input [3:0] d, input [3:0] oe, output [3:0] q);
		h_d <= d;
		h_oe <= oe;
		half();
		q = io_in;
		sck_pin <= 1;
		half();
		sck_pin <= 0;
	endtask
	// Shift n clocks of w bits, MSB first
	task automatic send(input [31:0] v, input int n, input int w);
		logic [3:0] q;
		for (int i = n - 1; i >= 0; i--)
			beat(w == 4 ? v[i*4 +: 4] : {3'h0, v[i]}, w == 4 ? 4'hf : 4'h1, q);
	endtask
	// Release lines and collect n clocks
	task automatic recv(input int n, input int w, output logic [127:0] r);
		logic [3:0] q;
		r = '0;
		for (int i = 0; i < n; i++) begin
			beat(4'h0, 4'h0, q);
			r = w == 4 ? {r[123:0], q} : {r[126:0], q[1]};
		end
	endtask
	task automatic start();
		@(posedge clk);
		cs_n_pin <= 0;
		half();
	endtask
	task automatic stop();
		half();
		cs_n_pin <= 1;
		half();
	endtask
endmodule // fqm_host

// [testbench/tb_fqm_core.sv]
// Bench for fqm_core: register bus tasks and serial frames via fqm_host.
// Assumes a 200 MHz clock and active-low asynchronous reset.
`timescale 1ns/1ps
module tb_fqm_core;
	localparam [7:0] MK = 8'h5a; // Arbitrary value
	localparam [7:0] DV = 8'h3c; // Arbitrary value
	localparam [127:0] UN = 128'h0123456789abcdeffedcba9876543210;
	logic clk = 0;
	logic rst_n = 0;
	logic [3:0] avs_address = 0;
	logic avs_read = 0;
	logic avs_write = 0;
	logic [31:0] avs_writedata = 0;
	logic [3:0] avs_byteenable = 4'hf;
	wire [31:0] avs_readdata;
	wire avs_waitrequest, sck_pin, cs_n_pin;
	wire [3:0] io_in, io_out, io_oe;
	int fails = 0;
	int n_compared = 0;
	int cyc = 0;
	logic [127:0] r;
	logic [31:0] d, e;
	always #2.5 clk = ~clk;
	fqm_core #(.MAKER_CODE(MK), .DEVICE_CODE(DV), .UNIQUE_NUMBER(UN)) dut (
		.clk(clk), .rst_n(rst_n), .sck_pin(sck_pin), .cs_n_pin(cs_n_pin),
		.io_in(io_in), .io_out(io_out), .io_oe(io_oe),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));
	fqm_host host (.clk(clk), .io_out(io_out), .io_oe(io_oe),
		.sck_pin(sck_pin), .cs_n_pin(cs_n_pin), .io_in(io_in));
	task automatic end_sim();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string nm, input [127:0] got, input [127:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// One bus access, held until waitrequest is seen low
	task automatic bus(input we, input [3:0] a, input [31:0] wd,
		output [31:0] rd);
		int n;
		@(posedge clk);
		avs_address <= a;
		avs_read <= !we;
		avs_write <= we;
		avs_writedata <= wd;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50) fails++;
		rd = avs_readdata;
		avs_read <= 0;
		avs_write <= 0;
	endtask
	task automatic op(input [7:0] o, input q);
		if (q) host.send({24'h0, o}, 2, 4);
		else host.send({24'h0, o}, 8, 1);
	endtask
	task automatic cmd(input [7:0] o, input q);
		host.start();
		op(o, q);
		host.stop();
	endtask
	// Hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			fails++;
			end_sim();
		end
	end
	initial begin
		int dm, ln;
		repeat (20) @(posedge clk);
		rst_n <= 1;
		repeat (3) @(posedge clk);
		bus(0, 4'h4, 0, d);
		chk("status", d & 32'h331, 0);
		bus(0, 4'h1, 0, d);
		chk("unmapped", d, 0);
		bus(1, 4'h8, 32'ha5, d);
		bus(0, 4'h8, 0, d);
		chk("pattern", d[7:0], 8'ha5);
		cmd(8'h38, 0);
		host.start();
		op(8'hc0, 0);
		host.send(32'h11, 8, 1);
		host.stop();
		bus(0, 4'h4, 0, d);
		chk("qe clear", d & 32'h331, 0);
		host.start();
		op(8'h77, 0);
		host.send(32'h40, 8, 4);
		host.stop();
		bus(1, 4'h0, 3, d);
		cmd(8'h38, 0);
		bus(0, 4'h4, 0, d);
		chk("enter", d & 32'h331, 32'h201);
		for (int k = 0; k < 4; k++) begin
			host.start();
			op(8'hc0, 1);
			host.send({k[1:0], 2'h0, k[1:0]}, 2, 4);
			host.stop();
			bus(0, 4'h4, 0, d);
			chk("param", d & 32'h331, 32'h1 | k << 4 | k << 8);
			dm = k == 0 ? 4 : k == 1 ? 6 : 8;
			ln = 8 << k;
			for (int i = 0; i < 4; i++)
				e = {e[23:0], 8'((ln - 2 + i) % ln) ^ 8'ha5};
			host.start();
			op(8'h0c, 1);
			host.send(ln - 2, 6, 4);
			host.recv(dm, 4, r);
			host.recv(8, 4, r);
			host.stop();
			chk("wrap read", r[31:0], e);
			host.start();
			op(8'heb, 1);
			host.send(32'h21, 6, 4);
			host.recv(dm, 4, r);
			host.recv(2, 4, r);
			host.stop();
			chk("quad fast", r[7:0], 8'h21 ^ 8'ha5);
		end
		host.start();
		op(8'hc0, 1);
		host.send(32'h13, 2, 4);
		host.stop();
		cmd(8'hff, 1);
		bus(0, 4'h4, 0, d);
		chk("exit", d & 32'h331, 32'h310);
		bus(0, 4'h0, 0, d);
		chk("latch", d[2:0], 3'h3);
		host.start();
		op(8'h0b, 0);
		host.send(32'h12, 24, 1);
		host.recv(8, 1, r);
		host.recv(8, 1, r);
		host.stop();
		chk("serial fast", r[7:0], 8'h12 ^ 8'ha5);
		bus(0, 4'hc, 0, d);
		chk("last op", d, 32'h0b);
		host.start();
		op(8'heb, 0);
		host.send(32'h34, 6, 4);
		host.send(32'hf0, 2, 4);
		host.recv(4, 4, r);
		host.recv(2, 4, r);
		host.stop();
		chk("serial quad fast", r[7:0], 8'h34 ^ 8'ha5);
		host.start();
		op(8'h94, 0);
		host.send(0, 6, 4);
		host.send(32'hf0, 2, 4);
		host.recv(4, 4, r);
		host.recv(8, 4, r);
		host.stop();
		chk("quad id", r[31:0], {MK, DV, MK, DV});
		host.start();
		op(8'h4b, 0);
		host.recv(32, 1, r);
		host.recv(128, 1, r);
		host.stop();
		chk("unique", r, UN);
		cmd(8'h66, 0);
		cmd(8'h99, 0);
		bus(0, 4'h4, 0, d);
		chk("reset cmd", d & 32'h331, 0);
		end_sim();
	end
endmodule // tb_fqm_core
bind fqm_core fqm_core_assertions chk_i (.clk(clk), .rst_n(rst_n),
	.sck_pin(sck_pin), .cs_n_pin(cs_n_pin), .io_out(io_out), .io_oe(io_oe),
	.avs_read(avs_read), .avs_write(avs_write),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
